/* File: rtl/acrp_pkg.sv */
package acrp_pkg;
   // Word sizes
   localparam int CFG_W = 14;
   localparam int RES_W = 16;
   localparam int WORD_W = RES_W + CFG_W;
   localparam int CFG_CNT_W = 4;
   localparam int EDGE_W = 6;

   // Configuration word field positions
   localparam int CFG_UPDATE_BIT = 13;
   localparam int INMODE_MSB = 12;
   localparam int INMODE_LSB = 10;
   localparam int CHAN_MSB = 9;
   localparam int CHAN_LSB = 7;
   localparam int FILTER_BIT = 6;
   localparam int REF_MSB = 5;
   localparam int REF_LSB = 3;
   localparam int SEQUENCER_MSB = 2;
   localparam int SEQUENCER_LSB = 1;
   localparam int READBACK_BIT = 0;

   // Active settings after reset, same as the all-ones preload
   localparam logic [CFG_W-1:0] CFG_RESET = 14'h3FFF;

   // Serial bit counts
   localparam logic [CFG_CNT_W-1:0] CFG_BITS = 4'hE;
   localparam logic [EDGE_W-1:0] RES_BITS_PLAIN = 6'h0F;
   localparam logic [EDGE_W-1:0] RES_BITS_BUSY = 6'h10;
   localparam logic [EDGE_W-1:0] CFG_READBACK_BITS = 6'h0E;
   localparam logic [EDGE_W-1:0] EDGE_SAT = 6'h3F;

   // Timing
   localparam int CLK_FREQ_KHZ = 10000;
   localparam int CONV_TIME_NS = 2200;
   // Longest time, so rounded down
   localparam int CONV_CYC = (CONV_TIME_NS * CLK_FREQ_KHZ / 1000000) < 1 ? 1 :
                             (CONV_TIME_NS * CLK_FREQ_KHZ / 1000000);

   // Buffering
   localparam int FIFO_DEPTH = 16;

   typedef enum logic {
      CONV_IDLE,
      CONV_RUN
   } acrp_conv_state_t;

   typedef enum logic [2:0] {
      IN_BIPOLAR_DIFF,
      IN_BIPOLAR_COM,
      IN_TEMP_SENSOR,
      IN_UNIPOLAR_DIFF,
      IN_UNIPOLAR_COM,
      IN_UNIPOLAR_GND
   } acrp_input_mode_t;

   localparam acrp_input_mode_t MODE_RESET = IN_UNIPOLAR_GND;
endpackage

/* File: rtl/acrp_stream_if.sv */
`timescale 1ns/10ps
interface acrp_stream_if #(parameter int W = 30);
   logic valid;
   logic ready;
   logic [W-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface

/* File: rtl/acrp_sync.sv */
`timescale 1ns/10ps
module acrp_sync #(
   parameter int W = 3
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   logic [W-1:0] meta_r;

   genvar g;
   generate
      for (g = 0; g < W; g++) begin : g_bit
         always_ff @(posedge clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
               meta_r[g] <= 1'b0;
               q_o[g] <= 1'b0;
            end else begin
               meta_r[g] <= d_i[g];
               q_o[g] <= meta_r[g];
            end
         end
      end
   endgenerate
endmodule

/* File: rtl/acrp_fifo.sv */
`timescale 1ns/10ps
module acrp_fifo #(
   parameter int W = 30,
   parameter int DEPTH = 16
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   acrp_stream_if.snk wr_i,
   acrp_stream_if.src rd_o
);
   // Depth must be a power of two, pointers wrap freely
   localparam int AW = $clog2(DEPTH);

   logic [W-1:0] mem_r [DEPTH];
   logic [W-1:0] data_r;
   logic [AW-1:0] wptr_r;
   logic [AW-1:0] rptr_r;
   logic [AW:0] count_r;

   wire push = wr_i.valid & wr_i.ready;
   wire pop = rd_o.valid & rd_o.ready;
   wire [AW-1:0] rptr_nxt = pop ? AW'(rptr_r + 1'b1) : rptr_r;
   wire [AW:0] count_nxt = (AW+1)'(count_r + (AW+1)'(push) - (AW+1)'(pop));
   // Head slot written this cycle, memory not yet holding it
   wire bypass = push & (count_r == (AW+1)'(pop));

   assign wr_i.ready = (count_r != (AW+1)'(DEPTH));
   assign rd_o.valid = (count_r != '0);
   assign rd_o.data = data_r;

   always_ff @(posedge clk_i) begin
      if (push) begin
         mem_r[wptr_r] <= wr_i.data;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wptr_r <= '0;
         rptr_r <= '0;
         count_r <= '0;
         data_r <= '0;
      end else begin
         wptr_r <= push ? AW'(wptr_r + 1'b1) : wptr_r;
         rptr_r <= rptr_nxt;
         count_r <= count_nxt;
         data_r <= bypass ? wr_i.data : mem_r[rptr_nxt];
      end
   end

   fifo_full_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (!wr_i.ready && !pop) |=> (!wr_i.ready && $stable(wptr_r)))
      else $error("fifo accepted a word while full");

   fifo_bound_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      count_r <= (AW+1)'(DEPTH))
      else $error("fifo count above depth");
endmodule

/* File: rtl/acrp_top.sv */
`timescale 1ns/10ps
module acrp_top #(
   parameter int FIFO_DEPTH = acrp_pkg::FIFO_DEPTH,
   parameter int CONV_CYCLES = acrp_pkg::CONV_CYC
) (
   input wire logic clk_sys_i,
   input wire logic reset_n_i,
   input wire logic convert_start_i,
   input wire logic serial_clock_i,
   input wire logic serial_config_i,
   input wire logic busy_mode_i,
   input wire logic [acrp_pkg::RES_W-1:0] conv_result_i,
   output logic serial_result_o,
   output logic conv_active_o,
   output logic conv_ready_o,
   output logic result_pending_o,
   output logic [acrp_pkg::CFG_W-1:0] cfg_active_o,
   output acrp_pkg::acrp_input_mode_t input_mode_o,
   output logic [2:0] channel_select_o,
   output logic filter_bandwidth_o,
   output logic [2:0] reference_select_o,
   output logic [1:0] sequencer_o,
   output logic config_readback_o
);
   localparam int WORD_W = acrp_pkg::WORD_W;
   localparam int SH_W = WORD_W + 1;
   localparam int CNT_W = $clog2(CONV_CYCLES + 1);
   localparam int CONV_D = CONV_CYCLES;

   // Pin synchronisers and edge finding
   logic [2:0] pins_s;
   logic start_d_r;
   logic sck_d_r;

   acrp_sync #(.W(3)) u_sync (
      .clk_i(clk_sys_i),
      .rst_n_i(reset_n_i),
      .d_i({convert_start_i, serial_clock_i, serial_config_i}),
      .q_o(pins_s)
   );

   wire start_s = pins_s[2];
   wire sck_s = pins_s[1];
   wire din_s = pins_s[0];
   wire start_rise = start_s & ~start_d_r;
   wire sel = ~start_s;
   wire sck_rise_sel = sck_s & ~sck_d_r & sel;
   wire sck_fall_sel = ~sck_s & sck_d_r & sel;

   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         start_d_r <= 1'b0;
         sck_d_r <= 1'b0;
      end else begin
         start_d_r <= start_s;
         sck_d_r <= sck_s;
      end
   end

   // Conversion timing
   acrp_pkg::acrp_conv_state_t state_r;
   acrp_pkg::acrp_conv_state_t state_nxt;
   logic [CNT_W-1:0] conv_cnt_r;
   logic eoc_d_r;

   acrp_stream_if #(.W(WORD_W)) wr_if ();
   acrp_stream_if #(.W(WORD_W)) rd_if ();

   wire run = (state_r == acrp_pkg::CONV_RUN);
   // start on rising edge; a full queue drops it
   wire conv_start = start_rise & ~run & wr_if.ready;
   wire eoc = run & (conv_cnt_r == CNT_W'(CONV_CYCLES - 1));

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         acrp_pkg::CONV_IDLE: begin
            if (conv_start) begin
               state_nxt = acrp_pkg::CONV_RUN;
            end
         end
         acrp_pkg::CONV_RUN: begin
            if (eoc) begin
               state_nxt = acrp_pkg::CONV_IDLE;
            end
         end
         default: begin
            state_nxt = acrp_pkg::CONV_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         state_r <= acrp_pkg::CONV_IDLE;
         conv_cnt_r <= '0;
         eoc_d_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         conv_cnt_r <= conv_start ? '0 : (run ? CNT_W'(conv_cnt_r + 1'b1) : conv_cnt_r);
         eoc_d_r <= eoc;
      end
   end

   // Configuration capture
   logic [acrp_pkg::CFG_W-1:0] cfg_sh_r;
   logic [acrp_pkg::CFG_CNT_W-1:0] cfg_cnt_r;
   logic [acrp_pkg::CFG_W-1:0] pend_r;
   logic pend_v_r;
   logic [acrp_pkg::CFG_W-1:0] cfg_active_r;
   acrp_pkg::acrp_input_mode_t mode_r;
   acrp_pkg::acrp_input_mode_t mode_nxt;

   // stop taking bits once the word is full
   wire cfg_take = sck_rise_sel & (cfg_cnt_r != acrp_pkg::CFG_BITS);
   wire cfg_done = cfg_take & (cfg_cnt_r == acrp_pkg::CFG_CNT_W'(acrp_pkg::CFG_BITS - 1'b1));
   wire [acrp_pkg::CFG_W-1:0] cfg_sh_nxt = {cfg_sh_r[acrp_pkg::CFG_W-2:0], din_s};
   wire cfg_apply = eoc & pend_v_r & pend_r[acrp_pkg::CFG_UPDATE_BIT];
   wire [2:0] inmode = pend_r[acrp_pkg::INMODE_MSB:acrp_pkg::INMODE_LSB];

   always_comb begin
      case (inmode)
         3'h0, 3'h1: mode_nxt = acrp_pkg::IN_BIPOLAR_DIFF;
         3'h2: mode_nxt = acrp_pkg::IN_BIPOLAR_COM;
         3'h3: mode_nxt = acrp_pkg::IN_TEMP_SENSOR;
         3'h4, 3'h5: mode_nxt = acrp_pkg::IN_UNIPOLAR_DIFF;
         3'h6: mode_nxt = acrp_pkg::IN_UNIPOLAR_COM;
         default: mode_nxt = acrp_pkg::IN_UNIPOLAR_GND;
      endcase
   end

   // Word spans bursts, so the count restarts only at conversion end
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         cfg_sh_r <= '0;
         cfg_cnt_r <= '0;
      end else begin
         cfg_sh_r <= cfg_take ? cfg_sh_nxt : cfg_sh_r;
         cfg_cnt_r <= eoc ? '0 : (cfg_take ? acrp_pkg::CFG_CNT_W'(cfg_cnt_r + 1'b1) : cfg_cnt_r);
      end
   end

   // pending word moves over at conversion end when its update bit is set
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         pend_r <= '0;
         pend_v_r <= 1'b0;
         cfg_active_r <= acrp_pkg::CFG_RESET;
         mode_r <= acrp_pkg::MODE_RESET;
      end else begin
         pend_r <= cfg_done ? cfg_sh_nxt : pend_r;
         pend_v_r <= cfg_done | (pend_v_r & ~eoc);
         cfg_active_r <= cfg_apply ? pend_r : cfg_active_r;
         mode_r <= cfg_apply ? mode_nxt : mode_r;
      end
   end

   assign cfg_active_o = cfg_active_r;
   assign input_mode_o = mode_r;
   assign channel_select_o = cfg_active_r[acrp_pkg::CHAN_MSB:acrp_pkg::CHAN_LSB];
   assign filter_bandwidth_o = cfg_active_r[acrp_pkg::FILTER_BIT];
   assign reference_select_o = cfg_active_r[acrp_pkg::REF_MSB:acrp_pkg::REF_LSB];
   assign sequencer_o = cfg_active_r[acrp_pkg::SEQUENCER_MSB:acrp_pkg::SEQUENCER_LSB];
   assign config_readback_o = cfg_active_r[acrp_pkg::READBACK_BIT];

   // Result queue; words pair the result with its own config
   assign wr_if.valid = eoc;
   assign wr_if.data = {conv_result_i, cfg_active_r};
   assign conv_ready_o = wr_if.ready;
   assign result_pending_o = rd_if.valid;
   assign conv_active_o = run;

   acrp_fifo #(.W(WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk_i(clk_sys_i),
      .rst_n_i(reset_n_i),
      .wr_i(wr_if),
      .rd_o(rd_if)
   );

   // Result readout
   logic [SH_W-1:0] shift_r;
   logic [acrp_pkg::EDGE_W-1:0] edges_r;
   logic [acrp_pkg::EDGE_W-1:0] limit_r;
   logic consumed_r;
   logic out_r;

   wire [WORD_W-1:0] head = rd_if.data;
   // oldest queued result becomes the next readout after a conversion end
   wire load = eoc_d_r & consumed_r & rd_if.valid;
   // readback bit set means no readback
   wire [acrp_pkg::EDGE_W-1:0] limit_nxt = acrp_pkg::EDGE_W'(
      (busy_mode_i ? acrp_pkg::RES_BITS_BUSY : acrp_pkg::RES_BITS_PLAIN) +
      (head[acrp_pkg::READBACK_BIT] ? '0 : acrp_pkg::CFG_READBACK_BITS));
   wire [SH_W-1:0] load_word = busy_mode_i ? {1'b0, head} : {head, 1'b0};
   wire [SH_W-1:0] shift_nxt = {shift_r[SH_W-2:0], 1'b0};
   wire in_budget = (edges_r < limit_r);
   wire last_edge = sck_fall_sel & (acrp_pkg::EDGE_W'(edges_r + 1'b1) == limit_r);

   assign rd_if.ready = load;
   assign serial_result_o = out_r;

   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         shift_r <= '0;
         edges_r <= '0;
         limit_r <= '0;
      end else if (load) begin
         shift_r <= load_word;
         edges_r <= '0;
         limit_r <= limit_nxt;
      end else if (sck_fall_sel) begin
         shift_r <= shift_nxt;
         edges_r <= (edges_r == acrp_pkg::EDGE_SAT) ? edges_r : acrp_pkg::EDGE_W'(edges_r + 1'b1);
      end
   end

   // one bit per falling edge, zero past the budget
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         out_r <= 1'b0;
         consumed_r <= 1'b1;
      end else begin
         out_r <= load ? load_word[SH_W-1] : (sck_fall_sel ? (in_budget & shift_r[SH_W-2]) : out_r);
         consumed_r <= last_edge | (consumed_r & ~load);
      end
   end

   cfg_load_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
      cfg_apply |=> (cfg_active_r == $past(pend_r)) && !pend_v_r)
      else $error("config not moved over at conversion end");

   cfg_keep_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
      (eoc && pend_v_r && !pend_r[acrp_pkg::CFG_UPDATE_BIT]) |=> $stable(cfg_active_r))
      else $error("config changed with update bit clear");

   cfg_hold_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
      !eoc |=> $stable(cfg_active_r))
      else $error("config changed outside conversion end");

   cfg_capture_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
      cfg_done |=> pend_v_r && (pend_r == {$past(cfg_sh_r[acrp_pkg::CFG_W-2:0]), $past(din_s)}))
      else $error("config word not captured MSB first");

   cfg_ignore_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
      (cfg_cnt_r == acrp_pkg::CFG_BITS && !eoc) |=> (cfg_cnt_r == acrp_pkg::CFG_BITS) && $stable(cfg_sh_r))
      else $error("config input taken after fourteenth edge");

   conv_len_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
      conv_start |=> run [*2] ##(CONV_D - 2) eoc)
      else $error("conversion length wrong");

   conv_stall_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
      (start_rise && !run && !wr_if.ready) |=> !run)
      else $error("conversion started with full queue");

   res_shift_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
      (sck_fall_sel && !load && in_budget) |=> (serial_result_o == $past(shift_r[SH_W-2])))
      else $error("result bit not shifted on falling edge");

   res_quiet_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
      (sck_fall_sel && !load && !in_budget) |=> !serial_result_o)
      else $error("output not zero past the edge budget");

   res_pair_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
      load |=> (limit_r == $past(limit_nxt)) && (edges_r == '0) && !consumed_r)
      else $error("readout budget not set on load");

   conv_cycle_c: cover property (@(posedge clk_sys_i) disable iff (!reset_n_i)
      conv_start ##[1:300] eoc);
   cfg_update_c: cover property (@(posedge clk_sys_i) disable iff (!reset_n_i)
      cfg_apply);
   readout_c: cover property (@(posedge clk_sys_i) disable iff (!reset_n_i)
      load ##[1:1000] last_edge);
   queue_full_c: cover property (@(posedge clk_sys_i) disable iff (!reset_n_i)
      !wr_if.ready);
endmodule

/* File: dv/acrp_host_model.sv */
`timescale 1ns/10ps
module acrp_host_model (
   input wire logic clk_i,
   input wire logic result_i,
   output logic conv_o,
   output logic sck_o,
   output logic din_o
);
   logic got [0:31];

   initial begin
      conv_o = 1'b0;
      sck_o = 1'b0;
      din_o = 1'b0;
   end

   // Half of an 800 ns serial period
   task automatic half();
      repeat (4) @(negedge clk_i);
   endtask

   task automatic pulse();
      @(negedge clk_i);
      conv_o = 1'b1;
      repeat (3) @(negedge clk_i);
      conv_o = 1'b0;
      repeat (4) @(negedge clk_i);
   endtask

   // config MSB first, sample before each fall
   task automatic clk_bits(input logic [13:0] w, input int k0, input int k1);
      for (int k = k0; k <= k1; k++) begin
         din_o = (k <= 14) ? w[14-k] : 1'($urandom);
         half();
         sck_o = 1'b1;
         half();
         got[k-1] = result_i;
         sck_o = 1'b0;
      end
   endtask

   // last bit shows after the final fall
   task automatic last(input int n);
      half();
      half();
      got[n-1] = result_i;
   endtask
endmodule

/* File: dv/testbench.sv */
`timescale 1ns/10ps
module testbench;
   localparam int CONV = 300;
   logic clk = 1'b0;
   logic reset_n;
   logic busy;
   logic [15:0] res;
   logic conv_pin, sck, din, result_pin, conv_active, conv_ready, pending, filter, readback;
   logic [13:0] cfg_act;
   acrp_pkg::acrp_input_mode_t mode;
   logic [2:0] chan, refs;
   logic [1:0] sequencer;
   int bad_count = 0;
   int n_tests = 0;
   int cyc = 0;
   logic [13:0] m_cfg = 14'h3FFF;
   logic [13:0] pend;
   int pcnt = 0;
   logic [30:0] q[$];

   always #50 clk = ~clk;

   acrp_top #(.CONV_CYCLES(CONV)) dut (.clk_sys_i(clk), .reset_n_i(reset_n), .convert_start_i(conv_pin),
      .serial_clock_i(sck), .serial_config_i(din), .busy_mode_i(busy), .conv_result_i(res),
      .serial_result_o(result_pin), .conv_active_o(conv_active), .conv_ready_o(conv_ready),
      .result_pending_o(pending), .cfg_active_o(cfg_act), .input_mode_o(mode),
      .channel_select_o(chan), .filter_bandwidth_o(filter), .reference_select_o(refs),
      .sequencer_o(sequencer), .config_readback_o(readback));

   acrp_host_model host (.clk_i(clk), .result_i(result_pin), .conv_o(conv_pin), .sck_o(sck), .din_o(din));

   task automatic summarize();
      if (bad_count == 0 && n_tests > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         bad_count++;
         $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
      end
   endtask

   // Hang guard, about twice the expected run
   always @(posedge clk) begin
      cyc++;
      if (cyc == 25000) begin
         bad_count++;
         summarize();
      end
   end

   function automatic logic [2:0] mdec(input logic [2:0] f);
      case (f)
         3'h0, 3'h1: return 3'h0;
         3'h2: return 3'h1;
         3'h3: return 3'h2;
         3'h4, 3'h5: return 3'h3;
         3'h6: return 3'h4;
         default: return 3'h5;
      endcase
   endfunction

   task automatic start(input logic ok);
      res = 16'($urandom);
      host.pulse();
      // rising start begins a conversion unless full
      chk(conv_active, ok);
      if (ok) q.push_back({busy, res, m_cfg});
   endtask

   task automatic finish();
      int t;
      t = 0;
      while (conv_active !== 1'b0 && t < 400) begin
         @(negedge clk);
         t++;
      end
      chk(conv_active, 1'b0);
      // Config in force for this conversion is stored before the swap
      if (pcnt == 14 && pend[13]) m_cfg = pend;
      pcnt = 0;
      repeat (3) @(negedge clk);
      chk(cfg_act, m_cfg);
      chk({mode, chan, filter, refs, sequencer, readback}, {mdec(m_cfg[12:10]), m_cfg[9:0]});
   endtask

   task automatic read(input int md, input logic [13:0] w);
      logic [30:0] e;
      logic [31:0] sv, ev;
      int n, b;
      e = q.pop_front();
      b = int'(e[30]);
      n = b + (e[0] ? 16 : 30);
      sv = '0;
      ev = '0;
      // bursts end well before conversion end
      if (md == 2) begin
         host.clk_bits(w, 1, 6);
         start(1'b1);
         host.clk_bits(w, 7, n - 1);
      end else begin
         host.clk_bits(w, 1, n - 1);
      end
      host.last(n);
      for (int j = 0; j < n; j++) begin
         sv[j] = host.got[j];
         ev[j] = (b == 1 && j == 0) ? 1'b0 : e[29-j+b];
      end
      chk(sv, ev);
      // Later bits before the next end of conversion are dropped
      if (pcnt == 0) begin
         pend = w;
         pcnt = 14;
      end
   endtask

   initial begin
      logic [13:0] w;
      int k;
      reset_n = 1'b0;
      busy = 1'b0;
      res = 16'h0000;
      void'($urandom(32'h28f1));
      repeat (6) @(negedge clk);
      reset_n = 1'b1;
      @(negedge clk);
      chk({conv_active, conv_ready, pending, cfg_act}, {3'h2, 14'h3FFF});
      // dummy conversion with input held high
      host.clk_bits(14'h3FFF, 1, 15);
      host.last(16);
      pend = 14'h3FFF;
      pcnt = 14;
      start(1'b1);
      finish();
      for (int it = 0; it < 12; it++) begin
         w = 14'($urandom);
         w[13] = (it % 4 != 3);
         busy = 1'($urandom);
         if (it % 3 == 1) begin
            start(1'b1);
            read(1, w);
            chk(cfg_act, m_cfg);
         end else begin
            read(it % 3, w);
            if (it % 3 == 0) start(1'b1);
         end
         finish();
      end
      // Host stalls: queue fills until starts are refused
      k = 0;
      while (conv_ready === 1'b1 && k < 30) begin
         start(1'b1);
         finish();
         k++;
      end
      chk(k, acrp_pkg::FIFO_DEPTH);
      chk(pending, 1'b1);
      start(1'b0);
      // Full queue with an unread result only clears by reset
      reset_n = 1'b0;
      repeat (6) @(negedge clk);
      reset_n = 1'b1;
      q.delete();
      m_cfg = 14'h3FFF;
      pcnt = 0;
      @(negedge clk);
      chk({conv_active, cfg_act}, {1'b0, 14'h3FFF});
      chk({pending, conv_ready}, 2'h1);
      start(1'b1);
      finish();
      // only the first fourteen bits apply
      read(0, 14'($urandom));
      start(1'b1);
      finish();
      summarize();
   end
endmodule
